// >>> logic/scs_clock_ctrl.sv
/*
 * system clock select block: control register, gear divider,
 * peripheral source and prescaler, timer base source, clock-out pin,
 * converter clock gate and usb host reset.
 * assumes ref_clk is the high-speed clock and low_speed_clock is a
 * level already synchronous to it; derived clocks leave as ticks, the clock-out pin as a toggled level.
 */
`timescale 1ns/1ps
`include "scs_regs.svh"

module scs_clock_ctrl (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // register port
    input  wire logic [31:0]     addr,
    input  wire logic [31:0]     wdata,
    input  wire logic            wr,
    input  wire logic            rd,
    output      logic [31:0]     rdata,
    // clock sources
    input  wire logic            low_speed_clock,
    // derived clocks and controls
    output      scs_pkg::scs_tick_s tick,
    output      logic            clock_out_pin,
    output      logic            adc_clk_run,
    output      logic            usb_host_reset
);

    scs_pkg::scs_state_s st_ff;
    scs_pkg::scs_state_s nxt_st;

    // gear code to counter mask; reserved codes run undivided
    function automatic logic [2:0] gear_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        case (code)
            `SCS_GR_D2: m = 3'h1;
            `SCS_GR_D4: m = 3'h3;
            `SCS_GR_D8: m = 3'h7;
            default:    m = 3'h0;
        endcase
        return m;
    endfunction

    // prescaler code to mask; reserved codes behave as divide by one
    function automatic logic [4:0] presc_mask(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h00;
        if (code <= `SCS_PR_MAX) begin
            m = (6'h01 << code) - 6'h01;
        end
        return m[4:0];
    endfunction

    function automatic logic [31:0] sys_word(input scs_pkg::scs_ctrl_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`SCS_BIT_USB] = c.usb_rst;
        w[`SCS_BIT_ADC] = c.adc_stop;
        w[`SCS_OUT_HI:`SCS_OUT_LO] = c.out_sel;
        w[`SCS_BIT_TB] = c.tb_sel;
        w[`SCS_BIT_PS] = c.ps_sel;
        w[`SCS_PR_HI:`SCS_PR_LO] = c.presc;
        w[`SCS_GR_HI:`SCS_GR_LO] = c.gear;
        return w;
    endfunction

    logic        sys_hit;
    logic        map_hit;
    logic        fs_rise;
    logic        g_raw;
    logic        p_raw;
    logic        pr_raw;
    logic        t_raw;
    logic        h_raw;
    logic        out_tick;
    logic [31:0] offs;

    always_comb begin
        nxt_st = st_ff;

        // address decode relative to the block base
        offs    = addr - `SCS_BASE;
        sys_hit = (offs == `SCS_OFF_SYS);
        map_hit = sys_hit || (offs == `SCS_OFF_OSC) || (offs == `SCS_OFF_STBY)
                  || (offs == `SCS_OFF_PLL) || (offs == `SCS_OFF_CKSEL);

        // only implemented fields are stored, the rest is dropped
        if (wr && sys_hit) begin
            nxt_st.ctrl.usb_rst  = wdata[`SCS_BIT_USB];
            nxt_st.ctrl.adc_stop = wdata[`SCS_BIT_ADC];
            nxt_st.ctrl.out_sel  = wdata[`SCS_OUT_HI:`SCS_OUT_LO];
            nxt_st.ctrl.tb_sel   = wdata[`SCS_BIT_TB];
            nxt_st.ctrl.ps_sel   = wdata[`SCS_BIT_PS];
            nxt_st.ctrl.presc    = wdata[`SCS_PR_HI:`SCS_PR_LO];
            nxt_st.ctrl.gear     = wdata[`SCS_GR_HI:`SCS_GR_LO];
        end

        // read data valid only in the cycle after the strobe
        nxt_st.rdata = 32'h0000_0000;
        if (rd && sys_hit) begin
            nxt_st.rdata = sys_word(st_ff.ctrl) & `SCS_SYS_RMASK;
        end else if (rd && map_hit) begin
            // fields of the other map entries live elsewhere
            nxt_st.rdata = 32'h0000_0000;
        end

        // gear divider: free counter, tick on masked all-ones
        nxt_st.gear_cnt = st_ff.gear_cnt + 3'h1;
        g_raw = (st_ff.gear_cnt & gear_mask(st_ff.ctrl.gear))
                == gear_mask(st_ff.ctrl.gear);

        // peripheral source: gear tick or every high-speed edge
        p_raw = st_ff.ctrl.ps_sel ? 1'b1 : g_raw;

        // prescaler counts peripheral ticks only
        if (p_raw) begin
            nxt_st.presc_cnt = st_ff.presc_cnt + 5'h01;
        end
        pr_raw = p_raw && ((st_ff.presc_cnt & presc_mask(st_ff.ctrl.presc))
                 == presc_mask(st_ff.ctrl.presc));

        // low-speed edge seen as a tick
        nxt_st.fs_q = low_speed_clock;
        fs_rise = low_speed_clock && !st_ff.fs_q;

        t_raw = st_ff.ctrl.tb_sel ? fs_rise : p_raw;

        // every second gear tick gives system clock / 2
        if (g_raw) begin
            nxt_st.half = !st_ff.half;
        end
        h_raw = g_raw && st_ff.half;

        // pin toggles on the chosen tick: whole periods while out_sel and the dividers hold; a change can leave one short phase
        case (st_ff.ctrl.out_sel)
            `SCS_OUT_FS:   out_tick = fs_rise;
            `SCS_OUT_SYS2: out_tick = h_raw;
            `SCS_OUT_SYS:  out_tick = g_raw;
            `SCS_OUT_TMR:  out_tick = t_raw;
            default:       out_tick = 1'b0;
        endcase
        if (out_tick) begin
            nxt_st.pin = !st_ff.pin;
        end

        // gate is a register that follows the stop bit one cycle later, on any cycle, so the gate is glitch-free
        nxt_st.adc_run = !st_ff.ctrl.adc_stop;

        nxt_st.tick.gear   = g_raw;
        nxt_st.tick.periph = p_raw;
        nxt_st.tick.presc  = pr_raw;
        nxt_st.tick.timer  = t_raw;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff               <= '0;
            st_ff.ctrl.usb_rst  <= `SCS_RST_USB;
            st_ff.ctrl.adc_stop <= `SCS_RST_ADC;
            st_ff.ctrl.out_sel  <= `SCS_RST_OUT;
            st_ff.ctrl.tb_sel   <= `SCS_RST_TB;
            st_ff.ctrl.ps_sel   <= `SCS_RST_PS;
            st_ff.ctrl.presc    <= `SCS_RST_PR;
            st_ff.ctrl.gear     <= `SCS_RST_GR;
            st_ff.adc_run       <= ~`SCS_RST_ADC;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata          = st_ff.rdata;
    assign tick           = st_ff.tick;
    assign clock_out_pin  = st_ff.pin;
    assign adc_clk_run    = st_ff.adc_run;
    assign usb_host_reset = st_ff.ctrl.usb_rst;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_sys_read;
        rd && addr == `SCS_BASE + `SCS_OFF_SYS |=>
            rdata == (sys_word($past(st_ff.ctrl)) & `SCS_SYS_RMASK);
    endproperty
    a_sys_read: assert property (p_sys_read)
        else $error("system control read data wrong");

    property p_usb_reset;
        wr && addr == `SCS_BASE + `SCS_OFF_SYS |=>
            usb_host_reset == $past(wdata[`SCS_BIT_USB]);
    endproperty
    a_usb_reset: assert property (p_usb_reset)
        else $error("usb host reset does not follow write");

    property p_adc_gate;
        wr && addr == `SCS_BASE + `SCS_OFF_SYS ##1 !wr |=>
            adc_clk_run == !$past(wdata[`SCS_BIT_ADC], 2);
    endproperty
    a_adc_gate: assert property (p_adc_gate)
        else $error("converter clock gate wrong");

    property p_pin_cause;
        $changed(clock_out_pin) |-> $past(out_tick);
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("clock out pin moved without a tick");

    property p_timer_fs;
        st_ff.ctrl.tb_sel ##1 tick.timer |-> $past(fs_rise);
    endproperty
    a_timer_fs: assert property (p_timer_fs)
        else $error("timer base tick without low-speed edge");

    property p_periph_fast;
        st_ff.ctrl.ps_sel [*2] |-> tick.periph;
    endproperty
    a_periph_fast: assert property (p_periph_fast)
        else $error("undivided peripheral clock missed an edge");

    property p_presc_sub;
        tick.presc |-> tick.periph;
    endproperty
    a_presc_sub: assert property (p_presc_sub)
        else $error("prescaler tick outside peripheral tick");

    property p_gear_half;
        (st_ff.ctrl.gear == `SCS_GR_D2) [*3] ##0 tick.gear |=> !tick.gear;
    endproperty
    a_gear_half: assert property (p_gear_half)
        else $error("gear divide by two ticked twice in a row");

    property p_unused_zero;
        (rdata & ~`SCS_SYS_RMASK) == 32'h0000_0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused read bits not zero");

endmodule

// >>> pkg/scs_regs.svh
/*
 * register map, field positions, reset values and codes of the
 * system clock select block.
 * assumes a flat 32-bit byte address and 32-bit word registers.
 */
// Operation
// - clock control registers decode at fixed base, words 0x0000 to 0x0010.
// - usb host controller held in reset while bit 23 is one.
// - converter clock gated off while bit 20 is one; resets to zero.
// - clock-out pin driven from select field bits 17-16; resets to 01.
// - timer base from low-speed clock when bit 13 set, else peripheral source.
// - peripheral clock from gear clock when bit 12 clear, else undivided.
// - prescaler divides peripheral clock by 1 to 32; codes 110, 111 reserved.
// - gear field bits 2-0 divides high-speed clock by 1, 2, 4, 8.
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

`define SCS_BASE        32'h400f_4000
`define SCS_OFF_SYS     32'h0000_0000
`define SCS_OFF_OSC     32'h0000_0004
`define SCS_OFF_STBY    32'h0000_0008
`define SCS_OFF_PLL     32'h0000_000c
`define SCS_OFF_CKSEL   32'h0000_0010

`define SCS_BIT_USB     23
`define SCS_BIT_ADC     20
`define SCS_OUT_HI      17
`define SCS_OUT_LO      16
`define SCS_BIT_TB      13
`define SCS_BIT_PS      12
`define SCS_PR_HI       10
`define SCS_PR_LO       8
`define SCS_GR_HI       2
`define SCS_GR_LO       0
`define SCS_SYS_RMASK   32'h0093_3707

`define SCS_RST_USB     1'h0
`define SCS_RST_ADC     1'h0
`define SCS_RST_OUT     2'h1
`define SCS_RST_TB      1'h0
`define SCS_RST_PS      1'h0
`define SCS_RST_PR      3'h0
`define SCS_RST_GR      3'h0

`define SCS_OUT_FS      2'h0
`define SCS_OUT_SYS2    2'h1
`define SCS_OUT_SYS     2'h2
`define SCS_OUT_TMR     2'h3

`define SCS_GR_D1       3'h0
`define SCS_GR_D2       3'h4
`define SCS_GR_D4       3'h5
`define SCS_GR_D8       3'h6
`define SCS_PR_MAX      3'h5

`endif

// >>> pkg/scs_pkg.sv
/*
 * types shared by the system clock select block.
 * assumes scs_regs.svh for all numeric constants.
 */
package scs_pkg;

    // software-visible fields of system_clock_control
    typedef struct packed {
        logic       usb_rst;
        logic       adc_stop;
        logic [1:0] out_sel;
        logic       tb_sel;
        logic       ps_sel;
        logic [2:0] presc;
        logic [2:0] gear;
    } scs_ctrl_s;

    // clock event ticks, one cycle each
    typedef struct packed {
        logic gear;
        logic periph;
        logic presc;
        logic timer;
    } scs_tick_s;

    // whole module state
    typedef struct packed {
        scs_ctrl_s   ctrl;
        logic [2:0]  gear_cnt;
        logic [4:0]  presc_cnt;
        logic        fs_q;
        logic        half;
        logic        pin;
        logic        adc_run;
        scs_tick_s   tick;
        logic [31:0] rdata;
    } scs_state_s;

endpackage

// >>> tb/scs_clock_ctrl_tb.sv
/* self-checking bench for scs_clock_ctrl: register port, ticks, pin, controls.
   assumes scs_regs.svh on the include path and a 10 MHz ref_clk. */
`timescale 1ns/1ps
`include "scs_regs.svh"
module scs_clock_ctrl_tb;
    logic               ref_clk;
    logic               rst;
    logic [31:0]        addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
    logic [31:0]        rdata;
    logic               low_speed_clock = 1'b0;
    scs_pkg::scs_tick_s tick;
    logic               clock_out_pin;
    logic               adc_clk_run;
    logic               usb_host_reset;
    logic [31:0]        exp_q[$];
    logic [31:0]        rng;
    logic               rd_q = 1'b0;
    logic [2:0]         ls_cnt = 3'h0;
    logic [2:0]         gc[4] = '{3'h0, 3'h4, 3'h5, 3'h6};
    int                 num_errors;
    int                 checked;
    int                 cnt[5];

    scs_clock_ctrl dut (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .low_speed_clock(low_speed_clock), .tick(tick),
        .clock_out_pin(clock_out_pin), .adc_clk_run(adc_clk_run),
        .usb_host_reset(usb_host_reset)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // low-speed level, period 8 cycles, so 8 rising edges per 64-cycle window
    always @(posedge ref_clk) begin
        ls_cnt <= ls_cnt + 3'h1;
        low_speed_clock <= ls_cnt[2];
    end

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_q) begin
            check(rdata, exp_q.pop_front());
        end
        rd_q <= rd;
    end

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] xs(logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic [31:0] mk(logic [1:0] o, logic t, logic p, logic [2:0] pr,
                                       logic [2:0] g);
        return {14'h0, o, 2'h0, t, p, 1'h0, pr, 5'h0, g};
    endfunction

    task automatic wr_reg(logic [31:0] a, logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(logic [31:0] a, logic [31:0] e);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd <= 1'b0;
    endtask

    task automatic cfg(logic [31:0] d);
        // no conversion runs in this bench, so the stop bit may be set at once
        wr_reg(`SCS_BASE, d);
        rd_reg(`SCS_BASE, d & `SCS_SYS_RMASK);
        @(posedge ref_clk);
        check(usb_host_reset, d[23]);
        check(adc_clk_run, !d[20]);
    endtask

    // window of 64 cycles, a multiple of every period, so counts are exact
    task automatic count_win();
        logic p;
        cnt = '{default: 0};
        repeat (8) @(posedge ref_clk);
        p = clock_out_pin;
        repeat (64) begin
            @(posedge ref_clk);
            cnt[0] += tick.gear;
            cnt[1] += tick.periph;
            cnt[2] += tick.presc;
            cnt[3] += tick.timer;
            if (clock_out_pin !== p) cnt[4]++;
            p = clock_out_pin;
        end
    endtask

    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(100 * 8000);
        num_errors++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        addr = 32'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        rng = 32'h44;
        num_errors = 0;
        checked = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check(usb_host_reset, 1'b0);
        check(adc_clk_run, 1'b1);
        rd_reg(`SCS_BASE, 32'h0001_0000);
        // other map entries and a hole past them read zero, take no writes
        for (int i = 1; i < 6; i++) begin
            wr_reg(`SCS_BASE + 4 * i, 32'hffff_ffff);
            rd_reg(`SCS_BASE + 4 * i, 32'h0);
        end
        rd_reg(`SCS_BASE, 32'h0001_0000);
        repeat (6) begin
            rng = xs(rng);
            cfg(rng);
        end
        // all ones: host reset and converter stop set, reserved codes stored
        cfg(32'hffff_ffff);
        for (int i = 0; i < 4; i++) begin
            cfg(mk(2'h2, 1'b0, 1'b0, 3'h0, gc[i]));
            count_win();
            check(cnt[0], 64 >> i);
            check(cnt[1], 64 >> i);
            check(cnt[4], 64 >> i);
        end
        for (int i = 0; i < 6; i++) begin
            cfg(mk(2'h1, 1'b0, 1'b1, i[2:0], 3'h0));
            count_win();
            check(cnt[2], 64 >> i);
            check(cnt[4], 32);
        end
        cfg(mk(2'h0, 1'b1, 1'b1, 3'h0, 3'h6));
        count_win();
        check(cnt[1], 64);
        check(cnt[3], 8);
        check(cnt[4], 8);
        cfg(mk(2'h3, 1'b0, 1'b1, 3'h0, 3'h6));
        count_win();
        check(cnt[3], 64);
        check(cnt[4], 64);
        complete_run();
    end
endmodule
